// [hw/gpt_glue.sv]
// Paging, time keeping, interrupts and serial DMA glue logic
`timescale 1ns/10ps
module gpt_glue #(
  parameter int unsigned NCH_P = gpt_pkg::NCH
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // Processor address side
  input  wire logic [15:0]            cpu_addr,
  input  wire logic                   cpu_inst,
  input  wire logic [3:0][7:0]        page_wdata,
  input  wire logic [3:0]             page_we,
  input  wire logic                   boot_en_wdata,
  input  wire logic                   boot_en_we,
  output logic [21:0]                 phys_addr,
  output logic                        sel_eeprom,
  output logic                        sel_sram,
  output logic                        sel_boot,
  output logic                        sel_io,
  output logic                        boot_power,
  // Clocks out
  output logic                        ser_clk,
  output logic                        cpu_clk,
  // Time
  input  wire logic                   time_cmd,
  output gpt_pkg::gpt_time_t          time_now,
  output gpt_pkg::gpt_time_t          time_latch,
  output logic                        sec_tic,
  // Interrupts
  input  wire logic [3:0]             bc_irq,
  input  wire gpt_pkg::gpt_rate_t     tmr_rate,
  output logic                        cpu_irq,
  output logic                        tmr_irq,
  // Bus hold
  output logic                        hold_req,
  input  wire logic                   hold_ack,
  input  wire logic                   bc_dma_req,
  output logic                        bc_dma_gnt,
  // DMA channels (0..4 receive, 5 command out)
  input  wire logic [NCH_P-1:0]       ch_valid,
  input  wire logic [NCH_P-1:0][15:0] ch_data,
  input  wire logic [NCH_P-1:0]       ch_blk_end,
  output logic [NCH_P-1:0]            ch_ready,
  input  wire logic [NCH_P-1:0][2:0]  ch_size,
  input  wire logic [NCH_P-1:0][21:0] ch_base,
  input  wire logic [NCH_P-1:0][21:0] ch_out_ptr,
  output logic [NCH_P-1:0][21:0]      ch_in_ptr,
  output logic [NCH_P-1:0]            ch_ovr,
  // Memory write port, behind the two-entry buffer
  output gpt_pkg::gpt_xfer_t          mem_xfer,
  output logic                        mem_valid,
  input  wire logic                   mem_ready
);
  // ---------------- Paging
  logic [3:0][7:0] page_r;
  logic            boot_r;
  wire  [1:0]      seg      = cpu_inst ? 2'h0 : cpu_addr[15:14];
  wire  [7:0]      page_sel = page_r[seg];
  wire             io_hit   = (seg == 2'h0) && !cpu_inst &&
                              cpu_addr >= gpt_pkg::IO_BASE &&
                              cpu_addr <= gpt_pkg::IO_LAST;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      page_r <= {4{gpt_pkg::PAGE_RESET}};
      boot_r <= 1'b1;
    end else begin
      for (int i = 0; i < 4; i++)
        if (page_we[i]) page_r[i] <= page_wdata[i];
      if (boot_en_we) boot_r <= boot_en_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phys_addr  <= 22'h0;
      sel_eeprom <= 1'b0;
      sel_sram   <= 1'b0;
      sel_boot   <= 1'b0;
      sel_io     <= 1'b0;
      boot_power <= 1'b1;
    end else begin
      phys_addr  <= {page_sel[5:0], cpu_addr[13:0]};
      sel_eeprom <= !io_hit && page_sel[7:6] == gpt_pkg::MEM_EEPROM;
      sel_sram   <= !io_hit && page_sel[7:6] == gpt_pkg::MEM_SRAM;
      sel_boot   <= !io_hit && boot_r &&
                    page_sel[7:6] == gpt_pkg::MEM_BOOT;
      sel_io     <= io_hit;
      boot_power <= boot_r;
    end
  end

  // ---------------- Clock dividers
  logic [7:0] sdiv_r, cdiv_r;
  wire        us_tick = sdiv_r == 8'(gpt_pkg::SER_DIV - 1);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sdiv_r  <= 8'h00;
      cdiv_r  <= 8'h00;
      ser_clk <= 1'b0;
      cpu_clk <= 1'b0;
    end else begin
      sdiv_r  <= us_tick ? 8'h00 : sdiv_r + 8'h01;
      cdiv_r  <= (cdiv_r == 8'(gpt_pkg::CPU_DIV - 1)) ? 8'h00
                 : cdiv_r + 8'h01;
      ser_clk <= sdiv_r < 8'(gpt_pkg::SER_DIV / 2);
      cpu_clk <= cdiv_r < 8'(gpt_pkg::CPU_DIV / 2);
    end
  end

  // ---------------- Time counters and capture
  logic [2:0] tc_sync_r;
  wire        tc_edge = tc_sync_r[1] && !tc_sync_r[2];
  wire        roll    = us_tick &&
                        time_now.usec == gpt_pkg::US_PER_SEC;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tc_sync_r  <= 3'h0;
      time_now   <= '0;
      time_latch <= '0;
      sec_tic    <= 1'b0;
    end else begin
      tc_sync_r <= {tc_sync_r[1:0], time_cmd};
      if (us_tick)
        time_now.usec <= roll ? 20'h0 : time_now.usec + 20'h1;
      if (roll) time_now.sec <= time_now.sec + 16'h1;
      sec_tic <= roll;
      if (tc_edge) time_latch <= time_now;
    end
  end

  // ---------------- Interrupts
  // Period in microseconds counted from the tic, so phases line up each second
  logic [15:0] tper_r;
  wire  [15:0] tper_max = 16'((32'd1_000_000 >> 8) << tmr_rate) - 16'h1;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tper_r  <= 16'h0;
      tmr_irq <= 1'b0;
      cpu_irq <= 1'b0;
    end else begin
      cpu_irq <= |bc_irq;
      tmr_irq <= roll || (us_tick && tper_r == tper_max);
      if (roll) tper_r <= 16'h0;
      else if (us_tick)
        tper_r <= (tper_r == tper_max) ? 16'h0 : tper_r + 16'h1;
    end
  end

  // ---------------- DMA arbitration
  typedef enum { IDLE, WAIT_ACK, BC_OWN, XFER, DONE } dst_t;
  dst_t            st_r;
  logic [2:0]      cur_r, rr_r;
  logic [2:0]      pick;
  logic            pick_ok;
  logic            buf_rdy;
  wire  [NCH_P-1:0] want = ch_valid;

  always_comb begin
    pick    = 3'h0;
    pick_ok = 1'b0;
    for (int k = NCH_P - 1; k >= 0; k--) begin
      automatic int j = (int'(rr_r) + 1 + k) % NCH_P;
      if (want[j]) begin
        pick    = 3'(j);
        pick_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r       <= IDLE;
      cur_r      <= 3'h0;
      rr_r       <= 3'(NCH_P - 1);
      hold_req   <= 1'b0;
      bc_dma_gnt <= 1'b0;
    end else begin
      unique case (st_r)
        IDLE: if (bc_dma_req || pick_ok) begin
          hold_req <= 1'b1;
          st_r     <= WAIT_ACK;
        end
        WAIT_ACK: if (hold_ack) begin
          if (bc_dma_req) begin
            bc_dma_gnt <= 1'b1;
            st_r       <= BC_OWN;
          end else if (pick_ok) begin
            cur_r <= pick;
            rr_r  <= pick;
            st_r  <= XFER;
          end else st_r <= DONE;
        end
        BC_OWN: if (!bc_dma_req) begin
          bc_dma_gnt <= 1'b0;
          st_r       <= DONE;
        end
        XFER: if (!ch_valid[cur_r] || !buf_rdy) st_r <= DONE;
        DONE: begin
          // Keep the bus until the buffer has drained to memory
          if (cnt_r == 2'h0 && !mem_valid)
            hold_req <= 1'b0;
          if (!hold_req && !hold_ack) st_r <= IDLE;
        end
      endcase
    end
  end

  // ---------------- Per-channel pointers
  logic [NCH_P-1:0]            take;
  logic [NCH_P-1:0][21:0]      xptr_r;
  logic [NCH_P-1:0]            drop_r;
  wire                         in_xfer = st_r == XFER && hold_ack;

  genvar g;
  generate
    for (g = 0; g < NCH_P; g++) begin : g_ch
      // Mask of offset bits for 1k..128k byte buffers
      wire [21:0] omask = 22'((32'h400 << ch_size[g]) - 1);
      wire [21:0] nxt   = (ch_base[g] & ~omask) |
                          ((xptr_r[g] + 22'h2) & omask);
      wire        full  = nxt == ch_out_ptr[g];
      assign take[g]     = in_xfer && cur_r == 3'(g) && ch_valid[g] &&
                           buf_rdy;
      assign ch_ready[g] = take[g] || (drop_r[g] && ch_valid[g] &&
                           in_xfer && cur_r == 3'(g));
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          xptr_r[g]    <= 22'h0;
          ch_in_ptr[g] <= 22'h0;
          ch_ovr[g]    <= 1'b0;
          drop_r[g]    <= 1'b0;
        end else begin
          if (ch_in_ptr[g] == 22'h0 && xptr_r[g] == 22'h0) begin
            xptr_r[g]    <= ch_base[g];
            ch_in_ptr[g] <= ch_base[g];
          end else if (take[g] && full && g < NCH_P - 1) begin
            ch_ovr[g] <= 1'b1;
            drop_r[g] <= 1'b1;
            xptr_r[g] <= ch_in_ptr[g];
          end else if (drop_r[g]) begin
            if (ch_ready[g] && ch_blk_end[g])
              drop_r[g] <= 1'b0;
          end else if (take[g]) begin
            xptr_r[g] <= nxt;
            if (ch_blk_end[g]) ch_in_ptr[g] <= nxt;
          end
        end
      end
    end
  endgenerate

  // ---------------- Two-entry output buffer
  gpt_pkg::gpt_xfer_t buf_r [2];
  logic [1:0]         cnt_r;
  logic               rp_r, wp_r;
  gpt_pkg::gpt_xfer_t in_w;
  wire                push = |take & ~(|(take & drop_r));
  wire                pop  = mem_valid && mem_ready;
  // Receive channels write to memory; the command channel reads from it.
  wire                is_wr = cur_r != 3'(NCH_P - 1);
  assign buf_rdy = cnt_r != 2'h2;
  assign in_w    = '{addr: xptr_r[cur_r], data: ch_data[cur_r], wr: is_wr};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r     <= 2'h0;
      rp_r      <= 1'b0;
      wp_r      <= 1'b0;
      buf_r[0]  <= '0;
      buf_r[1]  <= '0;
      mem_valid <= 1'b0;
      mem_xfer  <= '0;
    end else begin
      if (push) begin
        buf_r[wp_r] <= in_w;
        wp_r <= ~wp_r;
      end
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      mem_valid <= (cnt_r + {1'b0, push} - {1'b0, pop}) != 2'h0;
      // An empty buffer forwards the new word, since its slot is not yet written
      mem_xfer  <= (cnt_r - {1'b0, pop} == 2'h0) ? in_w
                   : buf_r[pop ? ~rp_r : rp_r];
    end
  end
endmodule

// [include/gpt_pkg.sv]
// Constants and carrier types for the paging, time and DMA glue block
// How it works
// - Data space splits into four 16 kbyte segments, each with its own page register.
// - Instruction cycles always map through the first page register.
// - Boot memory has a programmable power enable.
// - Reset turns boot memory on and points page zero at it.
// - Any page register may select any block of nonvolatile, static RAM or boot memory.
// - Crystal clock divides down to an exact 1 MHz serial clock and others.
// - Readable 20-bit microsecond counter; its rollover makes the one-second tic.
// - Readable 16-bit seconds counter advanced by the tic, sent with time command.
// - Asynchronous time command captures both counters into a readable register.
// - All bus-protocol controller interrupts are ORed into one processor interrupt.
// - Periodic timing interrupt is phase aligned to the one-second tic.
// - Timing interrupt rate selects 256, 128, 64 or 32 Hz.
// - DMA raises hold, waits for grant, transfers, then releases the bus.
// - Bus ownership is arbitrated among controller DMA and six DMA channels (five receive, one command).
// - Each serial interface has a receive channel; one shared channel sends commands.
// - Each channel keeps transfer pointer, block input pointer and block output pointer.
// - Buffers wrap circularly without reinitialisation.
// - On over-run the channel stops writing to memory.
// - Over-run discards the block and rewinds to last complete block end.
// - Boot memory answers at the reset vector under the reset mapping.
// - Memory-mapped I/O region suppresses the low segment memory select.
// - Processor clock output runs at 8 MHz.
// - Over-run is flagged on a receive channel when the next transfer pointer reaches block output pointer.
// - Buffer size is a power of two from 1 to 128 kbytes, size aligned.
package gpt_pkg;
  localparam int unsigned CLK_HZ      = 48_000_000;
  localparam int unsigned SER_HZ      = 1_000_000;
  localparam int unsigned CPU_HZ      = 8_000_000;
  localparam int unsigned SER_DIV     = CLK_HZ / SER_HZ;
  localparam int unsigned CPU_DIV     = CLK_HZ / CPU_HZ;
  localparam logic [19:0] US_PER_SEC  = 20'hF423F;
  localparam int unsigned NCH         = 6;
  localparam int unsigned AW          = 22;
  // Page select codes: {memory type, block}
  localparam logic [1:0]  MEM_EEPROM  = 2'h0;
  localparam logic [1:0]  MEM_SRAM    = 2'h1;
  localparam logic [1:0]  MEM_BOOT    = 2'h2;
  localparam logic [7:0]  PAGE_RESET  = 8'h80;
  localparam logic [15:0] IO_BASE     = 16'h1C00;
  localparam logic [15:0] IO_LAST     = 16'h1FFF;
  localparam logic [15:0] RESET_VEC   = 16'h2080;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [15:0]   data;
    logic          wr;
  } gpt_xfer_t;

  typedef struct packed {
    logic [19:0] usec;
    logic [15:0] sec;
  } gpt_time_t;

  typedef enum logic [1:0] { R256, R128, R64, R32 } gpt_rate_t;
endpackage

// [verification/gpt_bus_model.sv]
// Processor hold and memory side stand-in for the glue block
`timescale 1ns/10ps
module gpt_bus_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Hold handshake and memory
  input  wire logic hold_req,
  output logic      hold_ack,
  output logic      mem_ready
);
  logic [1:0] dly_r;
  logic [1:0] stall_r;
  // Grant lags two cycles so the requester must really wait for it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dly_r   <= 2'h0;
      stall_r <= 2'h0;
    end else begin
      dly_r   <= hold_req ? {dly_r[0], 1'b1} : 2'h0;
      stall_r <= stall_r + 2'h1;
    end
  end
  assign hold_ack  = hold_req & dly_r[1];
  // One stall in four keeps the output buffer under pressure
  assign mem_ready = hold_ack & (stall_r != 2'h3);
endmodule

// [verification/gpt_glue_properties.sv]
// Port-level checks on the glue block
`timescale 1ns/10ps
module gpt_glue_chk #(
  parameter int unsigned NCH_P = gpt_pkg::NCH
) (
  // Clock and reset
  input wire logic               clk,
  input wire logic               reset_n,
  // Address side
  input wire logic [15:0]        cpu_addr,
  input wire logic               cpu_inst,
  input wire logic               sel_eeprom,
  input wire logic               sel_sram,
  input wire logic               sel_boot,
  input wire logic               sel_io,
  // Clocks and interrupts
  input wire logic               ser_clk,
  input wire logic               cpu_clk,
  input wire logic [3:0]         bc_irq,
  input wire logic               cpu_irq,
  // Bus and DMA
  input wire logic               hold_req,
  input wire logic               hold_ack,
  input wire logic [NCH_P-1:0]   ch_ready,
  input wire logic [NCH_P-1:0]   ch_ovr,
  input wire gpt_pkg::gpt_xfer_t mem_xfer,
  input wire logic               mem_valid,
  input wire logic               mem_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire in_io = cpu_addr >= gpt_pkg::IO_BASE && cpu_addr <= gpt_pkg::IO_LAST;
  cpu_period_a: assert property (
    $rose(cpu_clk) |-> ##6 $rose(cpu_clk)) else $error("cpu clock period");
  ser_period_a: assert property (
    $rose(ser_clk) |-> ##48 $rose(ser_clk)) else $error("serial clock period");
  io_decode_a: assert property (
    in_io && !cpu_inst |=> sel_io) else $error("io region not decoded");
  sel_onehot_a: assert property (
    $onehot0({sel_eeprom, sel_sram, sel_boot, sel_io}))
    else $error("two selects at once");
  irq_merge_a: assert property (
    1'b1 |=> cpu_irq == $past(|bc_irq)) else $error("interrupt merge");
  bus_owned_a: assert property (
    mem_valid |-> hold_req && hold_ack) else $error("write without hold");
  ready_owned_a: assert property (
    |ch_ready |-> hold_ack) else $error("channel ready without bus");
  xfer_hold_a: assert property (
    mem_valid && !mem_ready |=> mem_valid && $stable(mem_xfer))
    else $error("stalled write changed");
  ovr_sticky_a: assert property (
    1'b1 |=> (ch_ovr & $past(ch_ovr)) == $past(ch_ovr))
    else $error("overrun flag cleared");
  cmd_no_ovr_a: assert property (
    ch_ovr[NCH_P-1] == 1'b0) else $error("command channel overrun");
endmodule
bind gpt_glue gpt_glue_chk #(.NCH_P(NCH_P)) gpt_glue_chk_inst (
  .clk(clk), .reset_n(reset_n), .cpu_addr(cpu_addr), .cpu_inst(cpu_inst),
  .sel_eeprom(sel_eeprom), .sel_sram(sel_sram), .sel_boot(sel_boot),
  .sel_io(sel_io), .ser_clk(ser_clk), .cpu_clk(cpu_clk), .bc_irq(bc_irq),
  .cpu_irq(cpu_irq), .hold_req(hold_req), .hold_ack(hold_ack),
  .ch_ready(ch_ready), .ch_ovr(ch_ovr), .mem_xfer(mem_xfer),
  .mem_valid(mem_valid), .mem_ready(mem_ready));

// [verification/gpt_glue_tb.sv]
// Self-checking bench for the glue block
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module gpt_glue_tb;
  logic               clk, reset_n, cpu_inst, boot_en_wdata, boot_en_we;
  logic               time_cmd, hold_ack, bc_dma_req, mem_ready, hold_req;
  logic               bc_dma_gnt, mem_valid, boot_power, ser_clk, cpu_clk;
  logic               sel_eeprom, sel_sram, sel_boot, sel_io;
  logic               sec_tic, cpu_irq, tmr_irq;
  logic [15:0]        cpu_addr;
  logic [3:0][7:0]    page_wdata;
  logic [3:0]         page_we, bc_irq;
  logic [5:0]         ch_valid, ch_blk_end, ch_ready, ch_ovr;
  logic [5:0][15:0]   ch_data;
  logic [5:0][2:0]    ch_size;
  logic [5:0][21:0]   ch_base, ch_out_ptr, ch_in_ptr;
  logic [21:0]        phys_addr;
  gpt_pkg::gpt_rate_t tmr_rate;
  gpt_pkg::gpt_time_t time_now, time_latch, l;
  gpt_pkg::gpt_xfer_t mem_xfer, got[$];
  int                 fails, check_count, cyc, e;

  gpt_glue gpt_glue_inst (.*);
  gpt_bus_model gpt_bus_model_inst (.clk(clk), .reset_n(reset_n),
    .hold_req(hold_req), .hold_ack(hold_ack), .mem_ready(mem_ready));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= reset_n ? cyc + 1 : 0;
  always @(posedge clk) begin
    if (reset_n && mem_valid === 1'b1 && mem_ready === 1'b1)
      got.push_back(mem_xfer);
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Selects are {eeprom, sram, boot, io}; outputs land one edge later
  task automatic look(logic [15:0] a, logic i, logic [3:0] s, logic [19:0] p);
    cpu_addr = a;
    cpu_inst = i;
    tick(1);
    `CHK("select", s, {sel_eeprom, sel_sram, sel_boot, sel_io})
    if (s != 4'h1) `CHK("phys", p, phys_addr[19:0])
  endtask
  task automatic t_map();
    `CHK("boot on", 1'b1, boot_power)
    look(16'h2080, 1'b0, 4'h2, {6'h00, 14'h2080});
    page_wdata[1] = 8'h03;
    page_wdata[2] = 8'h45;
    page_we = 4'h6;
    tick(1);
    page_we = 4'h0;
    look(16'h4010, 1'b0, 4'h8, {6'h03, 14'h0010});
    look(16'h8123, 1'b0, 4'h4, {6'h05, 14'h0123});
    look(16'h8123, 1'b1, 4'h2, {6'h00, 14'h0123});
    look(16'h1BFF, 1'b0, 4'h2, {6'h00, 14'h1BFF});
    look(16'h1C00, 1'b0, 4'h1, 20'h0);
    look(16'h1FFF, 1'b0, 4'h1, 20'h0);
    look(16'h2000, 1'b0, 4'h2, {6'h00, 14'h2000});
    $display("test map done");
  endtask
  task automatic t_boot_irq();
    for (int i = 0; i < 2; i++) begin
      boot_en_wdata = i[0];
      boot_en_we = 1'b1;
      tick(1);
      boot_en_we = 1'b0;
      tick(1);
      `CHK("boot power", i[0], boot_power)
    end
    for (int i = 0; i < 4; i++) begin
      bc_irq = 4'h1 << i;
      tick(2);
      `CHK("irq on", 1'b1, cpu_irq)
      bc_irq = 4'h0;
      tick(2);
      `CHK("irq off", 1'b0, cpu_irq)
    end
    $display("test boot irq done");
  endtask
  task automatic t_time();
    tick(300);
    time_cmd = 1'b1;
    e = cyc / 48;
    `CHK("usec now", 1'b1, time_now.usec >= e - 1 && time_now.usec <= e + 1)
    tick(6);
    `CHK("latch", 1'b1, time_latch.usec >= e - 1 && time_latch.usec <= e + 1)
    `CHK("latch sec", 16'h0, time_latch.sec)
    l = time_latch;
    tick(200);
    `CHK("held level", l, time_latch)
    time_cmd = 1'b0;
    tick(5);
    time_cmd = 1'b1;
    tick(6);
    `CHK("recapture", 1'b1, time_latch.usec > l.usec)
    $display("test time done");
  endtask
  task automatic send(logic [15:0] d, logic last);
    int n;
    ch_data[0] = d;
    ch_blk_end[0] = last;
    ch_valid[0] = 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ch_ready[0] !== 1'b1 && n < 100);
    #1;
    if (n == 100) begin
      fails++;
      test_done();
    end
  endtask
  task automatic drain();
    int n;
    ch_valid[0] = 1'b0;
    tick(2);
    for (n = 0; n < 200 && (hold_req | mem_valid) !== 1'b0; n++) tick(1);
    if (n == 200) begin
      fails++;
      test_done();
    end
  endtask
  task automatic t_dma();
    for (int i = 0; i < 4; i++) send(16'hA000 + i, i == 3);
    drain();
    `CHK("writes", 4, got.size())
    for (int i = 0; i < 4; i++) begin
      `CHK("addr", 22'h100000 + 2 * i, got[i].addr)
      `CHK("data", {16'hA000 + i, 1'b1}, {got[i].data, got[i].wr})
    end
    `CHK("in ptr", 22'h100008, ch_in_ptr[0])
    for (int i = 0; i < 8; i++) send(16'hB000 + i, i == 7);
    drain();
    `CHK("overrun", 1'b1, ch_ovr[0])
    foreach (got[i]) `CHK("no overwrite", 1'b1, got[i].addr < 22'h100010)
    `CHK("rewind", 22'h100008, ch_in_ptr[0])
    $display("test dma done");
  endtask
  task automatic t_bc();
    int n;
    bc_dma_req = 1'b1;
    for (n = 0; n < 50 && bc_dma_gnt !== 1'b1; n++) tick(1);
    `CHK("bc grant", 1'b1, bc_dma_gnt & hold_ack)
    `CHK("bc alone", 6'h00, ch_ready)
    bc_dma_req = 1'b0;
    tick(4);
    `CHK("bc release", 1'b0, bc_dma_gnt)
    $display("test bus done");
  endtask

  initial begin
    {reset_n, cpu_inst, boot_en_wdata, boot_en_we, time_cmd} = 5'h0;
    {bc_dma_req, cpu_addr, page_wdata, page_we, bc_irq} = 0;
    {ch_valid, ch_blk_end, ch_data, ch_size} = 0;
    tmr_rate = gpt_pkg::R256;
    ch_base = 0;
    ch_out_ptr = 0;
    ch_base[0] = 22'h100000;
    ch_out_ptr[0] = 22'h100010;
    repeat (10) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_map();
    t_boot_irq();
    t_time();
    t_dma();
    t_bc();
    test_done();
  end
endmodule
